// ===== design/canceller_ctl.sv
`timescale 1ns/1ps
// Per-canceller control: detector gating and fast convergence timer
module canceller_ctl #(
  parameter int STEP_CYC = echo_adapt_pkg::FAST_STEP_CYC
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [7:0] ctl3_i,
  input wire logic [7:0] ctl4_i,
  input wire logic [7:0] cns_i,
  input wire logic path_change_i,
  input wire logic instab_i,
  input wire logic conv_restart_i,
  input wire logic [15:0] noise_i,
  output logic path_det_en_o,
  output logic instab_det_en_o,
  output logic estimate_clear_o,
  output logic fast_conv_o,
  output logic instab_event_o,
  output logic [15:0] noise_o
);
  logic [2:0] dur;
  logic take;
  logic restart;
  logic [31:0] cnt_q;
  logic [2:0] steps_q;
  logic [23:0] prod;

  assign dur = ctl4_i[echo_adapt_pkg::DUR_MSB:echo_adapt_pkg::DUR_LSB];
  // Path clear only counts while the detector is on
  assign take = path_change_i & ctl3_i[echo_adapt_pkg::BIT_PATH_DET]; // R6 R5
  assign restart = take | conv_restart_i;
  assign prod = noise_i * cns_i;

  // Detector enables follow the control bits
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      path_det_en_o <= 1'b0;
      instab_det_en_o <= 1'b0;
      instab_event_o <= 1'b0;
    end else begin
      path_det_en_o <= ctl3_i[echo_adapt_pkg::BIT_PATH_DET]; // R6
      instab_det_en_o <= ctl3_i[echo_adapt_pkg::BIT_INSTAB_EN]; // R2
      instab_event_o <= instab_i & ctl3_i[echo_adapt_pkg::BIT_INSTAB_EN]; // R2
    end
  end

  // Estimate clear pulse only with path clear set
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      estimate_clear_o <= 1'b0;
    end else begin
      estimate_clear_o <= take & ctl3_i[echo_adapt_pkg::BIT_PATH_CLR]; // R3 R4
    end
  end

  // Fast convergence lasts dur steps; zero means forever
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fast_conv_o <= 1'b1;
      cnt_q <= 32'h0000_0000;
      steps_q <= 3'h0;
    end else if (restart) begin
      fast_conv_o <= 1'b1; // R3 R4 R7
      cnt_q <= 32'h0000_0000;
      steps_q <= 3'h0;
    end else if (fast_conv_o && dur != 3'h0) begin
      // Longer code gives more steps: monotonic R12
      if (cnt_q >= 32'(STEP_CYC - 1)) begin
        cnt_q <= 32'h0000_0000;
        steps_q <= steps_q + 3'h1;
        if (steps_q + 3'h1 >= dur) begin
          fast_conv_o <= 1'b0; // R7 R12
        end
      end else begin
        cnt_q <= cnt_q + 32'h0000_0001;
      end
    end else if (dur == 3'h0) begin
      fast_conv_o <= 1'b1; // R8
    end
  end

  // Linear noise scaling, 80h is unity gain
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      noise_o <= 16'h0000;
    end else begin
      noise_o <= prod[22:7]; // R10 R11
    end
  end
endmodule

// ===== design/echo_adapt_control_regs.sv
`timescale 1ns/1ps
// Function
// R1 - Software writes zero to reserved bits
// R2 - Instability detector runs when its enable set
// R3 - Path clear set: erase estimate, fast converge
// R4 - Path clear low: keep estimate, fast converge
// R5 - Path clear ignored when detection disabled
// R6 - Path change detector runs when enabled
// R7 - Duration field sets fast convergence length
// R8 - Duration zero keeps fast convergence forever
// R9 - Control three at 08h/28h, four 09h/29h
// R10 - Noise scale 80h leaves level unchanged
// R11 - Noise scales linearly with value over 80h
// R12 - Longer duration code gives longer convergence
module echo_adapt_control_regs #(
  parameter int STEP_CYC = echo_adapt_pkg::FAST_STEP_CYC
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [9:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [1:0] path_change_i,
  input wire logic [1:0] instab_i,
  input wire logic [1:0] conv_restart_i,
  input wire logic [15:0] noise_a_i,
  input wire logic [15:0] noise_b_i,
  output logic [1:0] path_det_en_o,
  output logic [1:0] instab_det_en_o,
  output logic [1:0] estimate_clear_o,
  output logic [1:0] fast_conv_o,
  output logic [7:0] nlp_ramp_bits_a_o,
  output logic [7:0] nlp_ramp_bits_b_o,
  output logic [15:0] noise_a_o,
  output logic [15:0] noise_b_o
);
  logic [7:0] adapt_control_three_a_q;
  logic [7:0] adapt_control_four_a_q;
  logic [7:0] nlp_ramp_control_a_q;
  logic [7:0] adapt_control_three_b_q;
  logic [7:0] adapt_control_four_b_q;
  logic [7:0] nlp_ramp_control_b_q;
  logic [7:0] comfort_noise_scale_a_q;
  logic [7:0] comfort_noise_scale_b_q;
  logic [2:0] instab_seen_q [2];
  logic [1:0] instab_ev;
  logic [7:0] idx;
  logic req;
  logic wr;
  logic [7:0] wd;
  logic [7:0] rd_d;

  // Index is word address; low two bits are byte lane
  assign idx = wb_adr_i[9:2];
  assign req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wr = req & wb_we_i & wb_sel_i[0];
  assign wd = wb_dat_i[7:0];

  // Ack one cycle after the strobe, dropped the next
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= req;
    end
  end

  // Register writes; reserved bits are stored as zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      adapt_control_three_a_q <= echo_adapt_pkg::RST_CTL3;
      adapt_control_four_a_q <= echo_adapt_pkg::RST_CTL4;
      nlp_ramp_control_a_q <= echo_adapt_pkg::RST_NLP;
      adapt_control_three_b_q <= echo_adapt_pkg::RST_CTL3;
      adapt_control_four_b_q <= echo_adapt_pkg::RST_CTL4;
      nlp_ramp_control_b_q <= echo_adapt_pkg::RST_NLP;
      comfort_noise_scale_a_q <= echo_adapt_pkg::RST_CNS;
      comfort_noise_scale_b_q <= echo_adapt_pkg::RST_CNS;
    end else if (wr) begin
      // Masking guards logic against software ignoring zero fill R1
      unique case (idx)
        echo_adapt_pkg::IDX_CTL3_A:
          adapt_control_three_a_q <= wd & echo_adapt_pkg::MASK_CTL3; // R9
        echo_adapt_pkg::IDX_CTL4_A:
          adapt_control_four_a_q <= wd & echo_adapt_pkg::MASK_CTL4; // R9
        echo_adapt_pkg::IDX_NLP_A: nlp_ramp_control_a_q <= wd;
        echo_adapt_pkg::IDX_CTL3_B:
          adapt_control_three_b_q <= wd & echo_adapt_pkg::MASK_CTL3; // R9
        echo_adapt_pkg::IDX_CTL4_B:
          adapt_control_four_b_q <= wd & echo_adapt_pkg::MASK_CTL4; // R9
        echo_adapt_pkg::IDX_NLP_B: nlp_ramp_control_b_q <= wd;
        echo_adapt_pkg::IDX_CNS_A: comfort_noise_scale_a_q <= wd;
        echo_adapt_pkg::IDX_CNS_B: comfort_noise_scale_b_q <= wd;
        default: begin
        end
      endcase
    end
  end

  // Sticky status: set wins over the write-one clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      instab_seen_q[0] <= 3'h0;
      instab_seen_q[1] <= 3'h0;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (wr && idx == (i == 0 ? echo_adapt_pkg::IDX_STAT_A :
                          echo_adapt_pkg::IDX_STAT_B)) begin
          instab_seen_q[i] <= instab_seen_q[i] & ~wd[2:0];
        end
        if (estimate_clear_o[i]) begin
          instab_seen_q[i][echo_adapt_pkg::ST_CLEAR] <= 1'b1;
        end
        if (instab_ev[i]) begin
          instab_seen_q[i][echo_adapt_pkg::ST_INSTAB] <= 1'b1;
        end
      end
    end
  end

  // Read mux; unmapped addresses read zero and still ack
  always_comb begin
    rd_d = 8'h00;
    unique case (idx)
      echo_adapt_pkg::IDX_CTL3_A: rd_d = adapt_control_three_a_q;
      echo_adapt_pkg::IDX_CTL4_A: rd_d = adapt_control_four_a_q;
      echo_adapt_pkg::IDX_NLP_A: rd_d = nlp_ramp_control_a_q;
      echo_adapt_pkg::IDX_CTL3_B: rd_d = adapt_control_three_b_q;
      echo_adapt_pkg::IDX_CTL4_B: rd_d = adapt_control_four_b_q;
      echo_adapt_pkg::IDX_NLP_B: rd_d = nlp_ramp_control_b_q;
      echo_adapt_pkg::IDX_CNS_A: rd_d = comfort_noise_scale_a_q;
      echo_adapt_pkg::IDX_CNS_B: rd_d = comfort_noise_scale_b_q;
      echo_adapt_pkg::IDX_STAT_A:
        rd_d = {5'h00, instab_seen_q[0][2:1], fast_conv_o[0]};
      echo_adapt_pkg::IDX_STAT_B:
        rd_d = {5'h00, instab_seen_q[1][2:1], fast_conv_o[1]};
      default: rd_d = 8'h00;
    endcase
  end

  // Read data registered with the ack
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (req) begin
      wb_dat_o <= {24'h00_0000, rd_d};
    end
  end

  // Ramp bits pass through one more register stage on the way out
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      nlp_ramp_bits_a_o <= echo_adapt_pkg::RST_NLP;
      nlp_ramp_bits_b_o <= echo_adapt_pkg::RST_NLP;
    end else begin
      nlp_ramp_bits_a_o <= nlp_ramp_control_a_q;
      nlp_ramp_bits_b_o <= nlp_ramp_control_b_q;
    end
  end

  // Canceller A
  canceller_ctl #(.STEP_CYC(STEP_CYC)) u_ctl_a (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ctl3_i(adapt_control_three_a_q),
    .ctl4_i(adapt_control_four_a_q),
    .cns_i(comfort_noise_scale_a_q),
    .path_change_i(path_change_i[0]),
    .instab_i(instab_i[0]),
    .conv_restart_i(conv_restart_i[0]),
    .noise_i(noise_a_i),
    .path_det_en_o(path_det_en_o[0]),
    .instab_det_en_o(instab_det_en_o[0]),
    .estimate_clear_o(estimate_clear_o[0]),
    .fast_conv_o(fast_conv_o[0]),
    .instab_event_o(instab_ev[0]),
    .noise_o(noise_a_o)
  );

  // Canceller B
  canceller_ctl #(.STEP_CYC(STEP_CYC)) u_ctl_b (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ctl3_i(adapt_control_three_b_q),
    .ctl4_i(adapt_control_four_b_q),
    .cns_i(comfort_noise_scale_b_q),
    .path_change_i(path_change_i[1]),
    .instab_i(instab_i[1]),
    .conv_restart_i(conv_restart_i[1]),
    .noise_i(noise_b_i),
    .path_det_en_o(path_det_en_o[1]),
    .instab_det_en_o(instab_det_en_o[1]),
    .estimate_clear_o(estimate_clear_o[1]),
    .fast_conv_o(fast_conv_o[1]),
    .instab_event_o(instab_ev[1]),
    .noise_o(noise_b_o)
  );
endmodule

// ===== design/echo_adapt_pkg.sv
package echo_adapt_pkg;
  // Register indexes: one byte register per 32-bit word, so the byte
  // address on the bus is four times the index.
  localparam logic [7:0] IDX_CTL3_A = 8'h08;
  localparam logic [7:0] IDX_CTL4_A = 8'h09;
  localparam logic [7:0] IDX_NLP_A = 8'h0B;
  localparam logic [7:0] IDX_CTL3_B = 8'h28;
  localparam logic [7:0] IDX_CTL4_B = 8'h29;
  localparam logic [7:0] IDX_NLP_B = 8'h2B;
  localparam logic [7:0] IDX_CNS_A = 8'h10;
  localparam logic [7:0] IDX_CNS_B = 8'h30;
  localparam logic [7:0] IDX_STAT_A = 8'h11;
  localparam logic [7:0] IDX_STAT_B = 8'h31;
  localparam int ADDR_W = 8;
  // Reset values
  localparam logic [7:0] RST_CTL3 = 8'h0A;
  localparam logic [7:0] RST_CTL4 = 8'h50;
  localparam logic [7:0] RST_NLP = 8'h00;
  localparam logic [7:0] RST_CNS = 8'h80;
  localparam logic [7:0] CNS_UNITY = 8'h80;
  // Field positions
  localparam int BIT_INSTAB_EN = 3;
  localparam int BIT_PATH_CLR = 2;
  localparam int BIT_PATH_DET = 1;
  localparam int DUR_LSB = 4;
  localparam int DUR_MSB = 6;
  localparam logic [7:0] MASK_CTL3 = 8'h0E;
  localparam logic [7:0] MASK_CTL4 = 8'h70;
  // Fast convergence time per duration step
  localparam int FAST_STEP_MS = 1;
  localparam int CLK_KHZ = 40000;
  localparam int FAST_STEP_CYC = FAST_STEP_MS * CLK_KHZ;
  // Status bit positions
  localparam int ST_FAST = 0;
  localparam int ST_CLEAR = 1;
  localparam int ST_INSTAB = 2;
endpackage

// ===== sim/echo_adapt_props.sv
`timescale 1ns/1ps
// Port-level checks of bus handshake and path change handling
module echo_adapt_props #(
  parameter int STEP_CYC = 4
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic [1:0] path_change_i,
  input wire logic [1:0] conv_restart_i,
  input wire logic [1:0] path_det_en_o,
  input wire logic [1:0] estimate_clear_o,
  input wire logic [1:0] fast_conv_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // Request not yet answered, and a path change seen with detection on
  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  // Enable output lags its control bit a cycle, so it is read one later
  sequence s_pc_on;
    path_change_i[0] ##1 path_det_en_o[0];
  endsequence
  sequence s_pc_off;
    path_change_i[0] ##1 !path_det_en_o[0];
  endsequence
  a_ack_after_req: assert property (s_req |=> wb_ack_o)
    else $error("request not acknowledged next cycle");
  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_ack_needs_req: assert property (!(wb_cyc_i && wb_stb_i)
    |=> !wb_ack_o)
    else $error("ack without request");
  a_dat_high_zero: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0)
    else $error("upper read data not zero");
  a_clear_cause: assert property (estimate_clear_o[0]
    |-> $past(path_change_i[0]) && path_det_en_o[0])
    else $error("estimate cleared without path change");
  a_path_fast: assert property (s_pc_on |-> fast_conv_o[0])
    else $error("path change did not start fast convergence");
  a_restart_fast: assert property (conv_restart_i[0] |=> fast_conv_o[0])
    else $error("restart did not start fast convergence");
  a_det_off: assert property (s_pc_off
    |-> !estimate_clear_o[0])
    else $error("estimate cleared with detection off");
endmodule

bind echo_adapt_control_regs echo_adapt_props #(.STEP_CYC(STEP_CYC)) u_props (
  .clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_dat_o, .wb_ack_o, .path_change_i,
  .conv_restart_i, .path_det_en_o, .estimate_clear_o, .fast_conv_o);

// ===== sim/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  logic clk_i = 0, rst_i = 1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0;
  logic [9:0] wb_adr_i = 0;
  logic [3:0] wb_sel_i = 0;
  logic [31:0] wb_dat_i = 0, wb_dat_o;
  logic wb_ack_o;
  logic [1:0] path_change_i = 0, instab_i = 0, conv_restart_i = 0;
  logic [15:0] noise_a_i = 16'h1234, noise_b_i = 16'h1234;
  logic [15:0] noise_a_o, noise_b_o;
  logic [1:0] path_det_en_o, instab_det_en_o, estimate_clear_o, fast_conv_o;
  logic [7:0] nlp_ramp_bits_a_o, nlp_ramp_bits_b_o;
  int error_cnt = 0, compares = 0, cyc_cnt = 0;
  // Short step keeps duration tests to a few dozen cycles
  echo_adapt_control_regs #(.STEP_CYC(4)) u_echo_adapt_control_regs (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o),
    .path_change_i(path_change_i),
    .instab_i(instab_i),
    .conv_restart_i(conv_restart_i),
    .noise_a_i(noise_a_i),
    .noise_b_i(noise_b_i),
    .path_det_en_o(path_det_en_o),
    .instab_det_en_o(instab_det_en_o),
    .estimate_clear_o(estimate_clear_o),
    .fast_conv_o(fast_conv_o),
    .nlp_ramp_bits_a_o(nlp_ramp_bits_a_o),
    .nlp_ramp_bits_b_o(nlp_ramp_bits_b_o),
    .noise_a_o(noise_a_o),
    .noise_b_o(noise_b_o)
  );
  initial forever #12.5 clk_i = ~clk_i;
  // Hang guard
  always @(posedge clk_i) begin
    cyc_cnt <= cyc_cnt + 1;
    if (cyc_cnt == 5000) begin
      error_cnt++;
      test_done();
    end
  end
  task automatic test_done();
    $display("compares %0d mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic chk(logic [31:0] got, logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // One classic cycle; read data taken at the ack edge
  task automatic bus(logic we, logic [7:0] idx, logic [7:0] d,
                     output logic [31:0] q);
    @(posedge clk_i);
    {wb_cyc_i, wb_stb_i, wb_we_i} <= {2'b11, we};
    wb_adr_i <= {idx, 2'b00};
    wb_sel_i <= 4'hF;
    wb_dat_i <= {24'h0, d};
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    {wb_cyc_i, wb_stb_i, wb_we_i} <= 3'b000;
  endtask
  task automatic wr(logic [7:0] idx, logic [7:0] d);
    logic [31:0] q;
    bus(1'b1, idx, d, q);
  endtask
  task automatic rd(logic [7:0] idx, logic [7:0] exp);
    logic [31:0] q;
    bus(1'b0, idx, 8'h00, q);
    chk(q, {24'h0, exp});
  endtask
  // Path change on canceller A under a given control three value
  task automatic pc(logic [7:0] c3, logic clr, logic fast);
    wr(echo_adapt_pkg::IDX_CTL3_A, c3);
    repeat (10) @(posedge clk_i);
    #1 chk(fast_conv_o[0], 1'b0);
    @(posedge clk_i) path_change_i[0] <= 1'b1;
    @(posedge clk_i) path_change_i[0] <= 1'b0;
    #1 chk(estimate_clear_o[0], clr);
    chk(fast_conv_o[0], fast);
    chk(path_det_en_o[0], c3[1]);
    chk(instab_det_en_o[0], c3[3]);
  endtask
  initial begin
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(echo_adapt_pkg::IDX_CTL3_A, 8'h0A);
    rd(echo_adapt_pkg::IDX_CTL4_B, 8'h50);
    rd(echo_adapt_pkg::IDX_CTL3_B, 8'h0A);
    wr(8'h3F, 8'h55);
    rd(8'h3F, 8'h00);
    wr(echo_adapt_pkg::IDX_CTL3_A, 8'hFF);
    rd(echo_adapt_pkg::IDX_CTL3_A, 8'h0E);
    wr(echo_adapt_pkg::IDX_CTL4_A, 8'hFF);
    rd(echo_adapt_pkg::IDX_CTL4_A, 8'h70);
    $display("register test done");
    wr(echo_adapt_pkg::IDX_CTL4_A, 8'h10);
    pc(8'h0E, 1'b1, 1'b1);
    pc(8'h0A, 1'b0, 1'b1);
    pc(8'h0C, 1'b0, 1'b0);
    pc(8'h06, 1'b1, 1'b1);
    $display("path test done");
    // Codes 1 and 2 give four and eight cycles; code 0 never ends
    for (int d = 1; d < 3; d++) begin
      wr(echo_adapt_pkg::IDX_CTL4_A, 8'(d << 4));
      @(posedge clk_i) conv_restart_i[0] <= 1'b1;
      @(posedge clk_i) conv_restart_i[0] <= 1'b0;
      repeat (d * 4 - 2) @(posedge clk_i);
      #1 chk(fast_conv_o[0], 1'b1);
      repeat (5) @(posedge clk_i);
      #1 chk(fast_conv_o[0], 1'b0);
    end
    wr(echo_adapt_pkg::IDX_CTL4_A, 8'h00);
    repeat (40) @(posedge clk_i);
    #1 chk(fast_conv_o[0], 1'b1);
    $display("duration test done");
    wr(echo_adapt_pkg::IDX_CNS_A, 8'h40);
    @(posedge clk_i) instab_i <= 2'b11;
    @(posedge clk_i) instab_i <= 2'b00;
    repeat (3) @(posedge clk_i);
    #1 chk(noise_a_o, 16'h091A);
    chk(noise_b_o, 16'h1234);
    $display("noise test done");
    // Sticky status: B saw the instability event, A had it gated off
    rd(echo_adapt_pkg::IDX_STAT_A, 8'h03);
    rd(echo_adapt_pkg::IDX_STAT_B, 8'h04);
    wr(echo_adapt_pkg::IDX_STAT_B, 8'h04);
    rd(echo_adapt_pkg::IDX_STAT_B, 8'h00);
    wr(echo_adapt_pkg::IDX_NLP_B, 8'hA5);
    rd(echo_adapt_pkg::IDX_NLP_B, 8'hA5);
    #1 chk(nlp_ramp_bits_b_o, 8'hA5);
    chk(nlp_ramp_bits_a_o, 8'h00);
    chk(fast_conv_o[1], 1'b0);
    chk(instab_det_en_o, 2'b10);
    // Path change on canceller B with clear off keeps the estimate
    @(posedge clk_i) path_change_i <= 2'b10;
    @(posedge clk_i) path_change_i <= 2'b00;
    #1 chk(estimate_clear_o, 2'b00);
    chk(fast_conv_o[1], 1'b1);
    chk(path_det_en_o, 2'b11);
    $display("status test done");
    // Mid-run reset restarts fast convergence and clears sticky bits
    @(posedge clk_i) rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    #1 chk(fast_conv_o, 2'b11);
    rd(echo_adapt_pkg::IDX_STAT_A, 8'h01);
    rd(echo_adapt_pkg::IDX_CTL3_A, 8'h0A);
    $display("reset test done");
    test_done();
  end
endmodule
